//--- logic/ascii_cmd_parser.sv
// Line parser and reply generator for the ASCII flag and analog command set
//
// What this block does
// [R1] Carriage return ends every command and reply
// [R2] Hex station address follows delimiter; ours 01
// [R3] Selector 0000 writes all sixteen flags
// [R4] Selector 100x writes one flag, index x 0-F
// [R5] Value field hex, four flags per character
// [R6] Flag write acknowledged with >, address, CR
// [R7] Invalid operation answered ?, address, CR
// [R8] Syntax, framing or foreign address: silence
// [R9] Flag read returns >, address, hex flags
// [R10] Last character holds flags 0-3, LSB first
// [R11] Valid data replies start with >, except the mask read, which starts with !
// [R12] Single channel read takes channel 0-8
// [R13] Data field: sign, 4 digits, point, 3
// [R14] All-channel read concatenates every channel's field
// [R15] Calibrate command starts calibration, acknowledged with !
// [R16] Peak-high read: all channels or one
// [R17] Peak-low read: all channels or one
// [R18] Range query returns >, address, channel, range code
// [R19] Mask is two hex chars, 7-4 then 3-0
// [R20] Emit upper-case hex, accept either case
// [R21] Flags cleared at reset, updated in one cycle
`timescale 1ns/1ps
module ascii_cmd_parser #(
  parameter int FIFO_DEPTH = parser_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Command characters from the host
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  // Reply characters to the host
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Analog values and range codes from the measurement side
  input wire parser_pkg::analog_value_t cur_value [parser_pkg::NUM_CH],
  input wire parser_pkg::analog_value_t peak_high_value [parser_pkg::NUM_CH],
  input wire parser_pkg::analog_value_t peak_low_value [parser_pkg::NUM_CH],
  input wire logic [7:0] range_code [parser_pkg::NUM_CH],
  // Control and status outputs
  output logic [15:0] aux_flags,
  output logic [7:0] channel_mask_field,
  output logic calibrate_start
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    parser_pkg::phase_t phase;
    logic [parser_pkg::LINE_MAX-1:0][7:0] line;
    logic [parser_pkg::LEN_W-1:0] len;
    logic overflow;
    parser_pkg::reply_kind_t kind;
    parser_pkg::stage_t stage;
    logic [parser_pkg::LEN_W-1:0] idx;
    logic [3:0] ch;
    logic [3:0] ch_last;
    logic [3:0] pos;
    logic [15:0] flags;
    logic [7:0] mask;
    logic [7:0] range_ch;
    logic cal;
  } parser_state_t;

  parser_state_t s_r;
  parser_state_t s_nxt;
  logic push;
  logic push_ready;
  logic [7:0] push_char;

  assign rx_ready = (s_r.phase == parser_pkg::ST_RECV);
  assign aux_flags = s_r.flags;
  assign channel_mask_field = s_r.mask;
  assign calibrate_start = s_r.cal;

  // ----------------------------------------------------------------
  // Command decode, reply generation and sequencing
  // ----------------------------------------------------------------
  always_comb begin
    logic [parser_pkg::LINE_MAX-1:0][4:0] hv;
    logic [7:0] addr;
    logic frame_ok;
    logic syntax_err;
    logic vals_ok;
    logic [15:0] wr_val;
    logic [7:0] num;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [31:0] flag_word;
    logic [parser_pkg::LEN_W-1:0] rlen;
    logic [parser_pkg::LEN_W-1:0] k;
    logic [3:0] nib;
    parser_pkg::analog_value_t v;
    hv = '0;
    addr = 8'h00;
    frame_ok = 1'b0;
    syntax_err = 1'b0;
    vals_ok = 1'b1;
    wr_val = 16'h0000;
    num = 8'h00;
    b3 = s_r.line[3];
    b4 = s_r.line[4];
    flag_word = {16'h0000, s_r.flags};
    rlen = parser_pkg::RPL_SHORT;
    k = '0;
    nib = 4'h0;
    v = '0;
    s_nxt = s_r;
    s_nxt.cal = 1'b0;
    push = 1'b0;
    push_char = 8'h00;
    for (int i = 0; i < parser_pkg::LINE_MAX; i++) begin
      hv[i] = parser_pkg::hex_val(s_r.line[i]); // [R20]
    end
    case (s_r.phase)
      parser_pkg::ST_RECV: begin
        if (rx_valid) begin
          if (rx_data == parser_pkg::CH_CR) begin // [R1]
            addr = {hv[1][3:0], hv[2][3:0]};
            frame_ok = !s_r.overflow && (s_r.len >= parser_pkg::LEN_ALL) && hv[1][4] && hv[2][4] &&
                       (s_r.line[0] == parser_pkg::CH_HASH || s_r.line[0] == parser_pkg::CH_DOLLAR); // [R2]
            s_nxt.kind = parser_pkg::RK_NAK;
            s_nxt.stage = parser_pkg::SG_HEAD;
            s_nxt.idx = '0;
            s_nxt.pos = 4'h0;
            s_nxt.ch = 4'h0;
            s_nxt.ch_last = parser_pkg::LAST_CH;
            if (s_r.line[0] == parser_pkg::CH_HASH) begin
              if (s_r.len == parser_pkg::LEN_ALL) begin
                s_nxt.kind = parser_pkg::RK_CUR; // [R14]
              end else if (s_r.len == parser_pkg::LEN_ONE && parser_pkg::is_digit(b3)) begin
                if (b3[3:0] <= parser_pkg::LAST_CH) begin // [R12]
                  s_nxt.kind = parser_pkg::RK_CUR;
                  s_nxt.ch = b3[3:0];
                  s_nxt.ch_last = b3[3:0];
                end
              end else if (b3 == parser_pkg::CH_UP_V && b4 == parser_pkg::CH_LOW_D) begin
                for (int i = parser_pkg::SEL_POS; i < parser_pkg::LINE_MAX; i++) begin
                  if (i < int'(s_r.len) && !hv[i][4]) begin
                    vals_ok = 1'b0;
                  end
                end
                // Value field may be seven or eight characters; the last four carry the flags
                wr_val = {hv[s_r.len - 5'h4][3:0], hv[s_r.len - 5'h3][3:0],
                          hv[s_r.len - 5'h2][3:0], hv[s_r.len - 5'h1][3:0]}; // [R5] [R10]
                if (!vals_ok || (s_r.len != parser_pkg::LEN_WR_SHORT && s_r.len != parser_pkg::LEN_WR_LONG)) begin
                  syntax_err = 1'b1;
                end else if (s_r.line[5] == parser_pkg::CH_ZERO && s_r.line[6] == parser_pkg::CH_ZERO &&
                             s_r.line[7] == parser_pkg::CH_ZERO && s_r.line[8] == parser_pkg::CH_ZERO) begin
                  s_nxt.kind = parser_pkg::RK_GT; // [R6]
                  if (frame_ok && addr == parser_pkg::STATION_ADDR) begin
                    s_nxt.flags = wr_val; // [R3] [R21]
                  end
                end else if (s_r.line[5] == parser_pkg::CH_ONE && hv[6][3:0] == 4'h0 && hv[7][3:0] == 4'h0) begin
                  s_nxt.kind = parser_pkg::RK_GT;
                  if (frame_ok && addr == parser_pkg::STATION_ADDR) begin
                    s_nxt.flags[hv[8][3:0]] = wr_val[0]; // [R4] [R21]
                  end
                end
              end else if (b3 == parser_pkg::CH_UP_M && (b4 == parser_pkg::CH_UP_H || b4 == parser_pkg::CH_UP_L)) begin
                if (s_r.len == parser_pkg::LEN_PEAK_ALL) begin
                  s_nxt.kind = (b4 == parser_pkg::CH_UP_H) ? parser_pkg::RK_MAX : parser_pkg::RK_MIN; // [R16] [R17]
                end else if (s_r.len == parser_pkg::LEN_PEAK_ONE && parser_pkg::is_digit(s_r.line[5])) begin
                  if (s_r.line[5][3:0] <= parser_pkg::LAST_CH) begin
                    s_nxt.kind = (b4 == parser_pkg::CH_UP_H) ? parser_pkg::RK_MAX : parser_pkg::RK_MIN; // [R16] [R17]
                    s_nxt.ch = s_r.line[5][3:0];
                    s_nxt.ch_last = s_r.line[5][3:0];
                  end
                end else begin
                  syntax_err = 1'b1;
                end
              end else begin
                syntax_err = 1'b1;
              end
            end else begin
              num = {hv[4][3:0], hv[5][3:0]};
              if (s_r.len == parser_pkg::LEN_PEAK_ALL && b3 == parser_pkg::CH_UP_V && b4 == parser_pkg::CH_LOW_D) begin
                s_nxt.kind = parser_pkg::RK_FLAGS; // [R9]
              end else if (s_r.len == parser_pkg::LEN_ONE && b3 == parser_pkg::CH_ONE) begin
                s_nxt.kind = parser_pkg::RK_BANG;
                s_nxt.cal = frame_ok && (addr == parser_pkg::STATION_ADDR); // [R15]
              end else if (s_r.len == parser_pkg::LEN_ONE && b3 == parser_pkg::CH_SIX) begin
                s_nxt.kind = parser_pkg::RK_MASK; // [R19]
              end else if (s_r.len == parser_pkg::LEN_PEAK_ONE && hv[4][4] && hv[5][4]) begin
                if (b3 == parser_pkg::CH_FIVE) begin
                  s_nxt.kind = parser_pkg::RK_BANG;
                  if (frame_ok && addr == parser_pkg::STATION_ADDR) begin
                    s_nxt.mask = num; // [R19]
                  end
                end else if (b3 == parser_pkg::CH_UP_B && num < 8'(parser_pkg::NUM_CH)) begin
                  s_nxt.kind = parser_pkg::RK_RANGE; // [R18]
                  s_nxt.range_ch = num;
                end
              end
            end
            if (frame_ok && !syntax_err && addr == parser_pkg::STATION_ADDR) begin
              s_nxt.phase = parser_pkg::ST_EMIT;
            end // [R8]
            s_nxt.len = '0;
            s_nxt.overflow = 1'b0;
          end else if (s_r.len == parser_pkg::LEN_W'(parser_pkg::LINE_MAX)) begin
            s_nxt.overflow = 1'b1; // [R8]
          end else begin
            s_nxt.line[s_r.len] = rx_data;
            s_nxt.len = s_r.len + 5'h1;
          end
        end
      end
      parser_pkg::ST_EMIT: begin
        push = 1'b1;
        if (s_r.kind == parser_pkg::RK_CUR || s_r.kind == parser_pkg::RK_MAX || s_r.kind == parser_pkg::RK_MIN) begin
          if (s_r.kind == parser_pkg::RK_MAX) begin
            v = peak_high_value[s_r.ch];
          end else if (s_r.kind == parser_pkg::RK_MIN) begin
            v = peak_low_value[s_r.ch];
          end else begin
            v = cur_value[s_r.ch];
          end
          case (s_r.stage)
            parser_pkg::SG_HEAD: begin
              push_char = parser_pkg::CH_GT; // [R11]
            end
            parser_pkg::SG_BODY: begin
              if (s_r.pos == 4'h0) begin
                push_char = v.negative ? parser_pkg::CH_MINUS : parser_pkg::CH_PLUS; // [R13]
              end else if (s_r.pos == parser_pkg::FIELD_DOT) begin
                push_char = parser_pkg::CH_DOT; // [R13]
              end else if (s_r.pos < parser_pkg::FIELD_DOT) begin
                push_char = parser_pkg::hex_char(v.digits[3'(4'h7 - s_r.pos)]);
              end else begin
                push_char = parser_pkg::hex_char(v.digits[3'(4'h8 - s_r.pos)]);
              end
            end
            default: begin
              push_char = parser_pkg::CH_CR; // [R1]
            end
          endcase
          if (push_ready) begin
            case (s_r.stage)
              parser_pkg::SG_HEAD: begin
                s_nxt.stage = parser_pkg::SG_BODY;
              end
              parser_pkg::SG_BODY: begin
                if (s_r.pos == parser_pkg::FIELD_LAST) begin
                  s_nxt.pos = 4'h0;
                  if (s_r.ch == s_r.ch_last) begin
                    s_nxt.stage = parser_pkg::SG_TAIL;
                  end else begin
                    s_nxt.ch = s_r.ch + 4'h1; // [R14]
                  end
                end else begin
                  s_nxt.pos = s_r.pos + 4'h1;
                end
              end
              default: begin
                s_nxt.phase = parser_pkg::ST_RECV;
              end
            endcase
          end
        end else begin
          case (s_r.kind)
            parser_pkg::RK_FLAGS: rlen = parser_pkg::RPL_FLAGS;
            parser_pkg::RK_MASK: rlen = parser_pkg::RPL_MASK;
            parser_pkg::RK_RANGE: rlen = parser_pkg::RPL_RANGE;
            default: rlen = parser_pkg::RPL_SHORT;
          endcase
          k = s_r.idx - parser_pkg::RPL_PAY;
          if (s_r.idx == 5'h0) begin
            case (s_r.kind)
              parser_pkg::RK_NAK: push_char = parser_pkg::CH_QUERY; // [R7]
              parser_pkg::RK_BANG: push_char = parser_pkg::CH_BANG; // [R15]
              parser_pkg::RK_MASK: push_char = parser_pkg::CH_BANG;
              default: push_char = parser_pkg::CH_GT; // [R6] [R11]
            endcase
          end else if (s_r.idx == 5'h1) begin
            push_char = parser_pkg::hex_char(parser_pkg::STATION_ADDR[7:4]); // [R2]
          end else if (s_r.idx == 5'h2) begin
            push_char = parser_pkg::hex_char(parser_pkg::STATION_ADDR[3:0]);
          end else if (s_r.idx == rlen - 5'h1) begin
            push_char = parser_pkg::CH_CR; // [R1]
          end else begin
            if (s_r.kind == parser_pkg::RK_FLAGS) begin
              nib = flag_word[5'(5'h1C - {k[2:0], 2'h0}) +: 4]; // [R9] [R10]
            end else if (s_r.kind == parser_pkg::RK_MASK) begin
              nib = (k == 5'h0) ? s_r.mask[7:4] : s_r.mask[3:0]; // [R19]
            end else if (k == 5'h0) begin
              nib = s_r.range_ch[7:4];
            end else if (k == 5'h1) begin
              nib = s_r.range_ch[3:0];
            end else if (k == 5'h2) begin
              nib = range_code[s_r.range_ch[3:0]][7:4]; // [R18]
            end else begin
              nib = range_code[s_r.range_ch[3:0]][3:0];
            end
            push_char = parser_pkg::hex_char(nib); // [R20]
          end
          if (push_ready) begin
            if (s_r.idx == rlen - 5'h1) begin
              s_nxt.phase = parser_pkg::ST_RECV;
            end else begin
              s_nxt.idx = s_r.idx + 5'h1;
            end
          end
        end
      end
      default: begin
        s_nxt.phase = parser_pkg::ST_RECV;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
      s_r.flags <= parser_pkg::FLAGS_RESET; // [R21]
      s_r.mask <= parser_pkg::MASK_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Reply buffer; a stalled host holds the emitter and so the receiver
  // ----------------------------------------------------------------
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_char),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

endmodule

//--- shared/parser_pkg.sv
// Shared constants, types and helpers of the ASCII command parser
package parser_pkg;

  // ----------------------------------------------------------------
  // Characters of the line protocol
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_GT = 8'h3E;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_FIVE = 8'h35;
  localparam logic [7:0] CH_SIX = 8'h36;
  localparam logic [7:0] CH_UP_B = 8'h42;
  localparam logic [7:0] CH_UP_V = 8'h56;
  localparam logic [7:0] CH_LOW_D = 8'h64;
  localparam logic [7:0] CH_UP_M = 8'h4D;
  localparam logic [7:0] CH_UP_H = 8'h48;
  localparam logic [7:0] CH_UP_L = 8'h4C;

  // ----------------------------------------------------------------
  // Sizes, positions and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] STATION_ADDR = 8'h01;
  localparam int LINE_MAX = 20;
  localparam int LEN_W = 5;
  localparam int NUM_CH = 9;
  localparam logic [3:0] LAST_CH = 4'h8;
  localparam logic [3:0] FIELD_LAST = 4'h8;
  localparam logic [3:0] FIELD_DOT = 4'h5;
  localparam logic [LEN_W-1:0] LEN_ALL = 5'h03;
  localparam logic [LEN_W-1:0] LEN_ONE = 5'h04;
  localparam logic [LEN_W-1:0] LEN_PEAK_ALL = 5'h05;
  localparam logic [LEN_W-1:0] LEN_PEAK_ONE = 5'h06;
  localparam logic [LEN_W-1:0] LEN_WR_SHORT = 5'h10;
  localparam logic [LEN_W-1:0] LEN_WR_LONG = 5'h11;
  localparam int SEL_POS = 5;
  localparam int VAL_POS = 9;
  localparam logic [LEN_W-1:0] RPL_SHORT = 5'h04;
  localparam logic [LEN_W-1:0] RPL_FLAGS = 5'h0C;
  localparam logic [LEN_W-1:0] RPL_MASK = 5'h06;
  localparam logic [LEN_W-1:0] RPL_RANGE = 5'h08;
  localparam logic [LEN_W-1:0] RPL_PAY = 5'h03;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [7:0] MASK_RESET = 8'hFF;
  localparam int FIFO_DEPTH = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RECV = 2'h0,
    ST_EMIT = 2'h1
  } phase_t;

  typedef enum logic [3:0] {
    RK_GT = 4'h0,
    RK_BANG = 4'h1,
    RK_NAK = 4'h2,
    RK_FLAGS = 4'h3,
    RK_MASK = 4'h4,
    RK_RANGE = 4'h5,
    RK_CUR = 4'h6,
    RK_MAX = 4'h7,
    RK_MIN = 4'h8
  } reply_kind_t;

  typedef enum logic [1:0] {
    SG_HEAD = 2'h0,
    SG_BODY = 2'h1,
    SG_TAIL = 2'h3
  } stage_t;

  // Sign plus seven BCD digits, digits[6] being the thousands digit
  typedef struct packed {
    logic negative;
    logic [6:0][3:0] digits;
  } analog_value_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {valid, nibble}; either letter case is taken
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      d = c - 8'h30;
      return {1'b1, d[3:0]};
    end else if (c >= 8'h41 && c <= 8'h46) begin
      d = c - 8'h37;
      return {1'b1, d[3:0]};
    end else if (c >= 8'h61 && c <= 8'h66) begin
      d = c - 8'h57;
      return {1'b1, d[3:0]};
    end
    return 5'h00;
  endfunction

  // Upper case only on the way out
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    if (n < 4'hA) begin
      return CH_ZERO + {4'h0, n};
    end
    return 8'h37 + {4'h0, n};
  endfunction

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= CH_ZERO) && (c <= CH_NINE);
  endfunction

endpackage

//--- logic/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);

  // Pointers carry one extra bit so full and empty differ; DEPTH must be a power of two
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t s_r;
  fifo_state_t s_nxt;
  logic full;
  logic empty;

  assign empty = (s_r.wr == s_r.rd);
  assign full = (s_r.wr[AW-1:0] == s_r.rd[AW-1:0]) && (s_r.wr[AW] != s_r.rd[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s_r.mem[s_r.rd[AW-1:0]];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (in_valid && !full) begin
      s_nxt.mem[s_r.wr[AW-1:0]] = in_data;
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

//--- testbench/host_model.sv
// Host program model: sends command lines, collects reply characters
`timescale 1ns/1ps
module host_model (
  // Clock and pacing
  input wire logic clock,
  input wire logic slow,
  // Command characters
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // Reply characters
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data
);
  string got = "";
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Caller supplies whole lines with address field and closing CR
  task automatic send(string s);
    logic ok;
    @(posedge clock);
    for (int i = 0; i < s.len(); i++) begin
      #1;
      rx_valid = 1'b1;
      rx_data = s[i];
      do begin
        @(negedge clock);
        ok = rx_ready;
        @(posedge clock);
      end while (!ok);
    end
    #1;
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask
  // Half-rate draining lets the reply buffer fill and stall the emitter
  always @(posedge clock) begin
    if (tx_valid && tx_ready) got = {got, string'(tx_data)};
    tx_ready <= #1 (slow ? ~tx_ready : 1'b1);
  end
endmodule

//--- testbench/ascii_cmd_parser_props.sv
// Concurrent checks on the ports of the command parser
`timescale 1ns/1ps
module ascii_cmd_parser_props (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Streams
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  // Status
  input wire logic [15:0] aux_flags,
  input wire logic [7:0] channel_mask_field,
  input wire logic calibrate_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_flags_reset: assert property ($fell(rst) |-> aux_flags == 16'h0000)
    else $error("flags not cleared by reset");
  a_mask_reset: assert property ($fell(rst) |-> channel_mask_field == 8'hFF)
    else $error("mask not set by reset");
  a_flags_atomic: assert property ($changed(aux_flags) |-> !rx_ready)
    else $error("flags changed outside a completed line");
  a_mask_atomic: assert property ($changed(channel_mask_field) |-> !rx_ready)
    else $error("mask changed outside a completed line");
  a_cal_pulse: assert property (calibrate_start |-> !rx_ready ##1 !calibrate_start)
    else $error("calibrate pulse wrong");
  a_busy_after_cr: assert property ($fell(rx_ready) |-> $past(rx_valid && rx_data == parser_pkg::CH_CR))
    else $error("receiver stopped without a line end");
  a_reply_soon: assert property ($fell(rx_ready) |-> ##[0:3] tx_valid)
    else $error("reply did not start");
  a_reply_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply character dropped while stalled");
  a_resume_bounded: assert property ($fell(rx_ready) |-> ##[1:600] rx_ready)
    else $error("receiver never resumed");
endmodule
bind ascii_cmd_parser ascii_cmd_parser_props props_u (.clock(clock), .rst(rst), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .aux_flags(aux_flags), .channel_mask_field(channel_mask_field), .calibrate_start(calibrate_start));

//--- testbench/tb_ascii_cmd_parser.sv
// Self-checking testbench of the ASCII command parser
`timescale 1ns/1ps
module tb_ascii_cmd_parser;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, calibrate_start;
  logic [7:0] rx_data, tx_data, channel_mask_field;
  logic [15:0] aux_flags;
  logic [15:0] cal_count = 16'h0000;
  parser_pkg::analog_value_t cur [parser_pkg::NUM_CH];
  parser_pkg::analog_value_t hi [parser_pkg::NUM_CH];
  parser_pkg::analog_value_t lo [parser_pkg::NUM_CH];
  logic [7:0] rc [parser_pkg::NUM_CH];
  int errors = 0;
  int checked = 0;
  initial forever #5 clock = ~clock;
  initial for (int i = 0; i < parser_pkg::NUM_CH; i++) begin
    cur[i] = {i[0], 28'h1234560 + 28'(i)};
    hi[i] = {1'b0, 28'h9876500 + 28'(i)};
    lo[i] = {1'b1, 28'h0000100 + 28'(i)};
    rc[i] = 8'hA0 + 8'(i);
  end
  always @(posedge clock) if (calibrate_start === 1'b1) cal_count <= cal_count + 16'h0001;
  ascii_cmd_parser dut_u (.clock(clock), .rst(rst), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .cur_value(cur),
    .peak_high_value(hi), .peak_low_value(lo), .range_code(rc), .aux_flags(aux_flags),
    .channel_mask_field(channel_mask_field), .calibrate_start(calibrate_start));
  host_model host_u (.clock(clock), .slow(slow), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
  task chk_str(string got, string exp);
    checked++;
    if (got != exp) begin
      errors++;
      $display("wrong value at %0t: reply %s expected %s", $time, got, exp);
    end
  endtask
  task chk_v(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic string fld(parser_pkg::analog_value_t v);
    return $sformatf("%s%h%h%h%h.%h%h%h", v.negative ? "-" : "+", v.digits[6], v.digits[5],
      v.digits[4], v.digits[3], v.digits[2], v.digits[1], v.digits[0]);
  endfunction
  function automatic string all_f(parser_pkg::analog_value_t a [parser_pkg::NUM_CH]);
    string s;
    s = ">";
    foreach (a[i]) s = {s, fld(a[i])};
    return {s, "\015"};
  endfunction
  // Silent lines are judged after a fixed quiet span
  task run(string c, string e, logic [15:0] f);
    int n;
    host_u.got = "";
    host_u.send({c, "\015"});
    n = 0;
    while (host_u.got.len() < e.len() && n < 3000) begin
      @(posedge clock);
      n++;
    end
    repeat (20) @(posedge clock);
    chk_str(host_u.got, e);
    chk_v(aux_flags, f);
  endtask
  initial begin
    repeat (40000) @(posedge clock);
    errors++;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    chk_v(aux_flags, 16'h0000);
    chk_v({8'h00, channel_mask_field}, 16'h00FF);
    run("#01Vd00000000FFFF", ">01\015", 16'hFFFF);
    run("#01Vd100E0000000", ">01\015", 16'hBFFF);
    run("#01Vd00000000a5c3", ">01\015", 16'hA5C3);
    run("$01Vd", ">010000A5C3\015", 16'hA5C3);
    run("#01Vd200000000000", "?01\015", 16'hA5C3);
    run("#02Vd00000000FFFF", "", 16'hA5C3);
    run("#01Vd0000000G0000", "", 16'hA5C3);
    run("#01Vd0000000000000000000", "", 16'hA5C3);
    run("#012", {">", fld(cur[2]), "\015"}, 16'hA5C3);
    run("#019", "?01\015", 16'hA5C3);
    #1 slow = 1'b1;
    run("#01", all_f(cur), 16'hA5C3);
    run("#01MH", all_f(hi), 16'hA5C3);
    run("#01MH8", {">", fld(hi[8]), "\015"}, 16'hA5C3);
    run("#01ML", all_f(lo), 16'hA5C3);
    run("#01ML0", {">", fld(lo[0]), "\015"}, 16'hA5C3);
    run("$011", "!01\015", 16'hA5C3);
    chk_v(cal_count, 16'h0001);
    run("$01581", "!01\015", 16'hA5C3);
    chk_v({8'h00, channel_mask_field}, 16'h0081);
    run("$016", "!0181\015", 16'hA5C3);
    run("$01B03", ">0103A3\015", 16'hA5C3);
    run("$01B09", "?01\015", 16'hA5C3);
    end_sim;
  end
endmodule
